// ===== logic/php_flag_if.sv
// Interface carrying the conditioned peripheral flag between modules.
`timescale 1ns/1ps
interface php_flag_if;
  logic flagLevel;
  logic riseToReady;
  logic fallToBusy;

  modport src
  (
    output flagLevel,
    output riseToReady,
    output fallToBusy
  );
  modport dst
  (
    input flagLevel,
    input riseToReady,
    input fallToBusy
  );
endinterface

// ===== logic/php_flag_sync.sv
// Flag synchroniser and edge detector for the peripheral flag line.
`timescale 1ns/1ps
module php_flag_sync
(
  input  wire logic  clk,
  input  wire logic  rstn,
  input  wire logic  peripheral_flag_line,
  input  wire logic  invertFlag,
  php_flag_if.src    flag
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } php_sync_t;

  php_sync_t s_r;
  php_sync_t s_nxt;

  // The first stage feeds only the second; edges use the settled copies.
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = peripheral_flag_line;
    s_nxt.sync = s_r.meta;
    s_nxt.last = s_r.sync;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // High on the line means Ready unless the sense is inverted.
  assign flag.flagLevel   = s_r.sync ^ invertFlag;
  assign flag.riseToReady = (s_r.sync ^ invertFlag) & ~(s_r.last ^ invertFlag);
  assign flag.fallToBusy  = ~(s_r.sync ^ invertFlag) & (s_r.last ^ invertFlag);

endmodule

// ===== logic/php_pkg.sv
// Package of constants and types for the parallel handshake port.
package php_pkg;

  // -------------------------------------------------------------------------
  // Register map (APB byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] STAT_ADDR   = 8'h04;
  localparam logic [7:0] DOUT_ADDR   = 8'h08;
  localparam logic [7:0] DIN_ADDR    = 8'h0c;
  localparam logic [7:0] DLY_ADDR    = 8'h10;
  localparam logic [7:0] XFER_ADDR   = 8'h14;
  localparam logic [7:0] WORD_ADDR   = 8'h18;

  // -------------------------------------------------------------------------
  // Control register fields
  // -------------------------------------------------------------------------
  localparam int CTRL_FULL_BIT   = 0;
  localparam int CTRL_FINV_BIT   = 1;
  localparam int CTRL_FALL_BIT   = 2;
  localparam int CTRL_WORD_BIT   = 3;
  localparam int CTRL_DINV_BIT   = 4;
  localparam int CTRL_IEN_BIT    = 5;
  localparam int CTRL_AUXA_BIT   = 6;
  localparam int CTRL_AUXB_BIT   = 7;
  localparam int CTRL_CLR_BIT    = 8;
  localparam int CTRL_RST_BIT    = 9;
  localparam int CTRL_WIDTH      = 9;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 9'h000;

  // Transfer command register fields.
  localparam int XFER_DIR_BIT    = 0;

  // Status register fields.
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_REQ_BIT    = 1;
  localparam int STAT_FLAG_BIT   = 2;
  localparam int STAT_DONE_BIT   = 3;
  localparam int STAT_RST_BIT    = 4;

  // -------------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------------
  localparam int CLK_HZ          = 20_000_000;
  localparam int RESET_PULSE_US  = 15;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int DLY_WIDTH       = 16;
  localparam logic [DLY_WIDTH-1:0] DLY_RESET = 16'h0004;
  localparam int DATA_WIDTH      = 16;

  // -------------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAITRDY,
    ST_DELAY,
    ST_REQ,
    ST_LOWBYTE
  } php_state_t;

endpackage

// ===== logic/php_port.sv
// Parallel handshake port with APB register access.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// - Pulse output starts without checking flag.
// - Wait request delay before raising request.
// - Ready pulses: pulse normal or full inverted.
// - Output data stable while request set.
// - Busy edge clears request; no flag check.
// - Enter: direction high, then request immediately.
// - Reset at power-on, key, software.
// - Peripheral reset pulse low at least 15 us.
// - Reset clears the request line.
// - Reset zeroes data-out only if option set; power-on reset zeroes it always.
// - Reset clears the interrupt enable.
// - Reset keeps aux outputs and direction; software reset sets aux from its CTRL write; power-on reset clears both.
// - Byte mode sends high byte first.
// - Byte output on low lane, high zero.
// - Byte enter uses low lane only.
// - Word format or direct register moves 16 bits.
// - Data polarity selectable high or low true.
// - Fall source latches on Busy edge.
// - Rise source latches on Ready edge.
// - Full mode waits request clear and Ready.
module php_port
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        resetKey,
  input  wire logic        clearOptionFitted,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        peripheral_flag_line,
  input  wire logic [15:0] dataIn,
  output logic      [15:0] dataOut,
  output logic             transfer_request_line,
  output logic             directionLine,
  output logic             aux_control_out_a,
  output logic             aux_control_out_b,
  output logic             periphResetN,
  output logic             intEnable
);

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef struct packed {
    php_pkg::php_state_t        state;
    logic [php_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [php_pkg::DLY_WIDTH-1:0]  dly;
    logic [php_pkg::DLY_WIDTH-1:0]  cnt;
    logic [15:0]                wordBuf;
    logic                       isEnter;
    logic                       wordXfer;
    logic [15:0]                dinReg;
    logic                       done;
    logic [9:0]                 rstCnt;
    logic [31:0]                rdata;
    logic                       ready;
    logic                       err;
    logic [15:0]                dout;
    logic                       req;
    logic                       dir;
    logic                       auxA;
    logic                       auxB;
    logic                       presetN;
  } php_port_t;

  php_port_t r_r;
  php_port_t r_nxt;

  php_flag_if flagBus();

  // Flag conditioning; the inverted sense serves full mode with Ready pulses.
  php_flag_sync u_sync
  (
    .clk                  (clk),
    .rstn                 (rstn),
    .peripheral_flag_line (peripheral_flag_line),
    .invertFlag           (r_r.ctrl[php_pkg::CTRL_FINV_BIT]),
    .flag                 (flagBus.src)
  );

  logic        fullMode;
  logic        fallSrc;
  logic        dataInv;
  logic        setup;
  logic        access;
  logic        wrIf;
  logic        swReset;
  logic [15:0] dinTrue;

  assign fullMode = r_r.ctrl[php_pkg::CTRL_FULL_BIT];
  assign fallSrc  = r_r.ctrl[php_pkg::CTRL_FALL_BIT];
  assign dataInv  = r_r.ctrl[php_pkg::CTRL_DINV_BIT];
  assign setup    = psel & ~penable;
  assign access   = psel & penable & ~r_r.ready; // Each transfer acts once.
  assign wrIf     = access & pwrite;
  assign swReset  = wrIf && paddr == php_pkg::CTRL_ADDR && pwdata[php_pkg::CTRL_RST_BIT];
  // Data lines read through the selected polarity.
  assign dinTrue  = dataInv ? ~dataIn : dataIn;

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  always_comb
  begin
    r_nxt       = r_r;
    r_nxt.ready = 1'b0;
    r_nxt.err   = 1'b0;

    // Handshake sequencer.
    unique case (r_r.state)
      php_pkg::ST_IDLE:
      begin
      end
      php_pkg::ST_WAITRDY:
      begin
        // Full mode waits for a clear request and a Ready flag.
        if (!r_r.req && flagBus.flagLevel)
        begin
          r_nxt.state = r_r.isEnter ? php_pkg::ST_REQ : php_pkg::ST_DELAY;
          r_nxt.req   = r_r.isEnter;
          r_nxt.cnt   = r_r.dly;
        end
      end
      php_pkg::ST_DELAY:
      begin
        // Data is on the lines; hold off the request for the set delay.
        if (r_r.cnt == '0)
        begin
          r_nxt.req   = 1'b1;
          r_nxt.state = php_pkg::ST_REQ;
        end
        else
        begin
          r_nxt.cnt = r_r.cnt - 1'b1;
        end
      end
      php_pkg::ST_REQ:
      begin
        // Output data is untouched while the request stands.
        if (r_r.isEnter && fallSrc && flagBus.fallToBusy)
        begin
          r_nxt.dinReg = r_r.wordXfer ? dinTrue : {8'h00, dinTrue[7:0]};
        end
        if (r_r.isEnter && !fallSrc && flagBus.riseToReady)
        begin
          r_nxt.dinReg = r_r.wordXfer ? dinTrue : {8'h00, dinTrue[7:0]};
        end
        // The Busy edge ends the request.
        if (flagBus.fallToBusy)
        begin
          r_nxt.req = 1'b0;
          if (!r_r.isEnter && !r_r.wordXfer && !r_r.done)
          begin
            r_nxt.state = php_pkg::ST_LOWBYTE;
          end
          else
          begin
            r_nxt.state = php_pkg::ST_IDLE;
            r_nxt.done  = 1'b1;
          end
        end
      end
      php_pkg::ST_LOWBYTE:
      begin
        // Second byte of a word: low byte follows the high byte.
        r_nxt.dout  = {8'h00, r_r.wordBuf[7:0]} ^ {16{dataInv}};
        r_nxt.cnt   = r_r.dly;
        r_nxt.state = fullMode ? php_pkg::ST_WAITRDY : php_pkg::ST_DELAY;
        r_nxt.done  = 1'b1;
        r_nxt.isEnter = 1'b0;
      end
      default:
      begin
        r_nxt.state = php_pkg::ST_IDLE;
      end
    endcase

    // APB register access, decoded in the first access cycle; pready rises the cycle after.
    if (access)
    begin
      r_nxt.ready = 1'b1;
      r_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        php_pkg::CTRL_ADDR:
        begin
          r_nxt.rdata[php_pkg::CTRL_WIDTH-1:0] = r_r.ctrl;
          if (pwrite)
          begin
            r_nxt.ctrl = pwdata[php_pkg::CTRL_WIDTH-1:0];
            r_nxt.auxA = pwdata[php_pkg::CTRL_AUXA_BIT];
            r_nxt.auxB = pwdata[php_pkg::CTRL_AUXB_BIT];
          end
        end
        php_pkg::STAT_ADDR:
        begin
          r_nxt.rdata[php_pkg::STAT_BUSY_BIT] = r_r.state != php_pkg::ST_IDLE;
          r_nxt.rdata[php_pkg::STAT_REQ_BIT]  = r_r.req;
          r_nxt.rdata[php_pkg::STAT_FLAG_BIT] = flagBus.flagLevel;
          r_nxt.rdata[php_pkg::STAT_DONE_BIT] = r_r.done;
          r_nxt.rdata[php_pkg::STAT_RST_BIT]  = r_r.rstCnt != '0;
        end
        php_pkg::DOUT_ADDR:
        begin
          r_nxt.rdata[15:0] = r_r.dout;
        end
        php_pkg::DIN_ADDR:
        begin
          r_nxt.rdata[15:0] = r_r.dinReg;
        end
        php_pkg::DLY_ADDR:
        begin
          r_nxt.rdata[php_pkg::DLY_WIDTH-1:0] = r_r.dly;
          if (pwrite)
          begin
            r_nxt.dly = pwdata[php_pkg::DLY_WIDTH-1:0];
          end
        end
        php_pkg::XFER_ADDR:
        begin
          // A write starts a handshake when idle and the reset pulse has ended; otherwise it is refused.
          if (pwrite && r_r.state == php_pkg::ST_IDLE && r_r.rstCnt == '0)
          begin
            r_nxt.isEnter  = pwdata[php_pkg::XFER_DIR_BIT];
            r_nxt.wordXfer = r_r.ctrl[php_pkg::CTRL_WORD_BIT];
            r_nxt.wordBuf  = pwdata[31:16];
            r_nxt.done     = 1'b0;
            r_nxt.cnt      = r_r.dly;
            r_nxt.dir      = pwdata[php_pkg::XFER_DIR_BIT];
            if (!pwdata[php_pkg::XFER_DIR_BIT])
            begin
              // Word, or high byte first in byte mode.
              r_nxt.dout = (r_r.ctrl[php_pkg::CTRL_WORD_BIT] ? pwdata[31:16]
                           : {8'h00, pwdata[31:24]}) ^ {16{dataInv}};
              r_nxt.state = fullMode ? php_pkg::ST_WAITRDY : php_pkg::ST_DELAY;
            end
            else if (fullMode)
            begin
              r_nxt.state = php_pkg::ST_WAITRDY;
            end
            else
            begin
              // Direction settles one cycle before the request rises.
              r_nxt.cnt   = '0;
              r_nxt.state = php_pkg::ST_DELAY;
            end
          end
          else if (pwrite)
          begin
            r_nxt.err = 1'b1;
          end
        end
        php_pkg::WORD_ADDR:
        begin
          // Direct word access moves 16 bits with no handshake.
          r_nxt.rdata[15:0] = dinTrue;
          r_nxt.dir = ~pwrite;
          if (pwrite && r_r.state == php_pkg::ST_IDLE)
          begin
            r_nxt.dout = pwdata[15:0] ^ {16{dataInv}};
          end
        end
        default:
        begin
          r_nxt.err = 1'b1;
        end
      endcase
    end

    // Reset pulse counter.
    if (r_r.rstCnt != '0)
    begin
      r_nxt.rstCnt = r_r.rstCnt - 1'b1;
    end
    r_nxt.presetN = (r_nxt.rstCnt == '0);

    // Interface reset from the key or software; direction kept; aux lines kept by the key, set from the CTRL write by software.
    if (resetKey || swReset)
    begin
      r_nxt.rstCnt  = 10'(php_pkg::RESET_PULSE_CYC);
      r_nxt.presetN = 1'b0;
      r_nxt.req     = 1'b0;
      r_nxt.state   = php_pkg::ST_IDLE;
      r_nxt.ctrl[php_pkg::CTRL_IEN_BIT] = 1'b0;
      if (clearOptionFitted)
      begin
        r_nxt.dout = 16'h0000;
      end
    end
  end

  // Power-on reset also runs the full interface reset pulse.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      r_r         <= '0;
      r_r.state   <= php_pkg::ST_IDLE;
      r_r.ctrl    <= php_pkg::CTRL_RESET;
      r_r.dly     <= php_pkg::DLY_RESET;
      r_r.rstCnt  <= 10'(php_pkg::RESET_PULSE_CYC);
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign prdata                = r_r.rdata;
  assign pready                = r_r.ready;
  assign pslverr               = r_r.err;
  assign dataOut               = r_r.dout;
  assign transfer_request_line = r_r.req;
  assign directionLine         = r_r.dir;
  assign aux_control_out_a     = r_r.auxA;
  assign aux_control_out_b     = r_r.auxB;
  assign periphResetN          = r_r.presetN;
  assign intEnable             = r_r.ctrl[php_pkg::CTRL_IEN_BIT];

  logic unusedSetup;
  assign unusedSetup = setup;

endmodule

// ===== testbench/php_periph_model.sv
// Behavioural peripheral answering with ready-type flag pulses.
`timescale 1ns/1ps
module php_periph_model
(
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        dir,
  input  wire logic [15:0] dataOut,
  input  wire logic        slow,
  input  wire logic [15:0] enterValue,
  output logic             flag,
  output logic [15:0]      dataIn,
  output logic [15:0]      capLast,
  output logic [15:0]      capPrev
);
  int gap;

  // Each request gets data, Ready, then Busy; data is released afterwards.
  initial
  begin
    flag = 1'b0;
    dataIn = 16'h0000;
    capLast = 16'h0000;
    capPrev = 16'h0000;
    forever
    begin
      @(posedge clk);
      if (req === 1'b1)
      begin
        gap = slow ? 24 : 2;
        dataIn <= enterValue;
        repeat (gap) @(posedge clk);
        flag <= 1'b1;
        capPrev <= dir ? capPrev : capLast;
        capLast <= dir ? capLast : dataOut;
        repeat (gap) @(posedge clk);
        flag <= 1'b0;
        repeat (8) @(posedge clk);
        dataIn <= ~enterValue;
      end
    end
  end
endmodule

// ===== testbench/php_port_properties.sv
// Concurrent checks on the ports of the parallel handshake port.
`timescale 1ns/1ps
module php_port_properties
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        resetKey,
  input wire logic        clearOptionFitted,
  input wire logic        peripheral_flag_line,
  input wire logic [15:0] dataOut,
  input wire logic        transfer_request_line,
  input wire logic        directionLine,
  input wire logic        aux_control_out_a,
  input wire logic        aux_control_out_b,
  input wire logic        periphResetN,
  input wire logic        intEnable
);
  logic [9:0] lowCnt_r;
  logic [9:0] lowCnt_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Counts the cycles the peripheral reset line stays low, saturating.
  always_comb
    lowCnt_nxt = periphResetN ? 10'h000 : lowCnt_r + {9'h000, ~&lowCnt_r};
  always_ff @(posedge clk)
    lowCnt_r <= rstn ? lowCnt_nxt : 10'h001;

  property p_reqClear;
    transfer_request_line && $fell(peripheral_flag_line) |-> ##[1:5] !transfer_request_line;
  endproperty
  a_reqClear: assert property (p_reqClear) else $error("request not cleared");
  property p_doutHold;
    transfer_request_line && $past(transfer_request_line) |-> $stable(dataOut);
  endproperty
  a_doutHold: assert property (p_doutHold) else $error("data moved");
  property p_reqDelay;
    $rose(transfer_request_line) && !directionLine |-> $past(dataOut, 4) == dataOut;
  endproperty
  a_reqDelay: assert property (p_reqDelay) else $error("request too early");
  property p_dirHold;
    transfer_request_line |-> $stable(directionLine);
  endproperty
  a_dirHold: assert property (p_dirHold) else $error("direction moved");
  property p_rstOut;
    $rose(rstn) |-> !transfer_request_line && !periphResetN;
  endproperty
  a_rstOut: assert property (p_rstOut) else $error("reset outputs wrong");
  property p_pulseLen;
    $rose(periphResetN) |-> lowCnt_r >= 10'(php_pkg::RESET_PULSE_CYC);
  endproperty
  a_pulseLen: assert property (p_pulseLen) else $error("reset pulse short");
  property p_keyIen;
    resetKey |-> ##[1:2] (!intEnable && !periphResetN && !transfer_request_line);
  endproperty
  a_keyIen: assert property (p_keyIen) else $error("key reset wrong");
  property p_keyClr;
    resetKey && clearOptionFitted |-> ##[1:2] dataOut == 16'h0000;
  endproperty
  a_keyClr: assert property (p_keyClr) else $error("data not cleared");
  property p_keyKeep;
    resetKey |=> $stable(aux_control_out_a) && $stable(aux_control_out_b);
  endproperty
  a_keyKeep: assert property (p_keyKeep) else $error("aux moved");
endmodule

bind php_port php_port_properties php_port_properties_inst
(
  .clk                   (clk),
  .rstn                  (rstn),
  .resetKey              (resetKey),
  .clearOptionFitted     (clearOptionFitted),
  .peripheral_flag_line  (peripheral_flag_line),
  .dataOut               (dataOut),
  .transfer_request_line (transfer_request_line),
  .directionLine         (directionLine),
  .aux_control_out_a     (aux_control_out_a),
  .aux_control_out_b     (aux_control_out_b),
  .periphResetN          (periphResetN),
  .intEnable             (intEnable)
);

// ===== testbench/php_port_tb_top.sv
// Self-checking bench for the parallel handshake port.
`timescale 1ns/1ps
module php_port_tb_top;
  logic        clk, rstn, resetKey, clearOptionFitted, psel, penable, pwrite;
  logic        pready, pslverr, flag, req, dir, auxA, auxB, periphResetN, intEnable;
  logic        slow, rdErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdData;
  logic [15:0] dataIn, dataOut, enterValue, capLast, capPrev;
  int          n_mismatch, n_compared;

  php_port php_port_inst
  (
    .clk(clk), .rstn(rstn), .resetKey(resetKey), .clearOptionFitted(clearOptionFitted),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .peripheral_flag_line(flag),
    .dataIn(dataIn), .dataOut(dataOut), .transfer_request_line(req), .directionLine(dir),
    .aux_control_out_a(auxA), .aux_control_out_b(auxB), .periphResetN(periphResetN),
    .intEnable(intEnable)
  );
  php_periph_model php_periph_model_inst
  (
    .clk(clk), .req(req), .dir(dir), .dataOut(dataOut), .slow(slow),
    .enterValue(enterValue), .flag(flag), .dataIn(dataIn), .capLast(capLast),
    .capPrev(capPrev)
  );

  // Free-running 50 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic hang(input string what);
    n_mismatch++;
    $display("[ERR] %0t timeout %s", $time, what);
    test_done();
  endtask

  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    if (n >= 40)
      hang("apb");
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitIdle();
    for (int k = 0; k < 60; k++)
    begin
      apb(php_pkg::STAT_ADDR, 1'b0, 32'h0);
      if (rdData[php_pkg::STAT_BUSY_BIT] === 1'b0)
        return;
    end
    hang("busy");
  endtask

  task automatic waitPulse();
    for (int k = 0; k < 400; k++)
    begin
      @(posedge clk);
      if (periphResetN === 1'b1)
        return;
    end
    hang("reset pulse");
  endtask

  task automatic xfer(input logic d, input logic [15:0] w);
    apb(php_pkg::XFER_ADDR, 1'b1, {w, 15'h0000, d});
    checkVal({31'h0, rdErr}, 32'h0);
    waitIdle();
  endtask

  task automatic endTest(input string name);
    $display("test %s finished", name);
  endtask

  // Main sequence of register and handshake tests.
  initial
  begin
    {rstn, resetKey, clearOptionFitted, psel, penable, pwrite, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    enterValue = 16'h0000;
    n_mismatch = 0;
    n_compared = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    waitPulse();
    apb(php_pkg::CTRL_ADDR, 1'b0, 32'h0);
    checkVal(rdData, 32'h0);
    apb(php_pkg::DLY_ADDR, 1'b0, 32'h0);
    checkVal(rdData, {16'h0000, php_pkg::DLY_RESET});
    apb(8'h1c, 1'b0, 32'h0);
    checkVal({31'h0, rdErr}, 32'h1);
    endTest("registers");
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h0068);
    xfer(1'b0, 16'ha5c3);
    checkVal({16'h0, capLast}, 32'ha5c3);
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h0078);
    xfer(1'b0, 16'h00ff);
    checkVal({16'h0, capLast}, 32'hff00);
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h0040);
    xfer(1'b0, 16'h1234);
    checkVal({capPrev, capLast}, 32'h0012_0034);
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h004b);
    xfer(1'b0, 16'h5a3c);
    checkVal({16'h0, capLast}, 32'h5a3c);
    endTest("output");
    enterValue <= 16'hb7e1;
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h0048);
    xfer(1'b1, 16'h0000);
    apb(php_pkg::DIN_ADDR, 1'b0, 32'h0);
    checkVal({16'h0, rdData[15:0]}, 32'hb7e1);
    checkVal({31'h0, dir}, 32'h1);
    enterValue <= 16'h4d2a;
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h004c);
    xfer(1'b1, 16'h0000);
    apb(php_pkg::DIN_ADDR, 1'b0, 32'h0);
    checkVal({16'h0, rdData[15:0]}, 32'h4d2a);
    enterValue <= 16'hc35a;
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h0040);
    xfer(1'b1, 16'h0000);
    apb(php_pkg::DIN_ADDR, 1'b0, 32'h0);
    checkVal(rdData, 32'h0000_005a);
    endTest("enter");
    apb(php_pkg::WORD_ADDR, 1'b1, 32'h0000_9e17);
    checkVal({15'h0, req, dataOut}, 32'h9e17);
    apb(php_pkg::WORD_ADDR, 1'b0, 32'h0);
    checkVal({16'h0, rdData[15:0]}, 32'h3ca5);
    slow <= 1'b1;
    apb(php_pkg::XFER_ADDR, 1'b1, 32'h0f0f_0000);
    apb(php_pkg::XFER_ADDR, 1'b1, 32'h0f0f_0000);
    checkVal({31'h0, rdErr}, 32'h1);
    waitIdle();
    slow <= 1'b0;
    endTest("direct");
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h0200);
    checkVal({15'h0, periphResetN, dataOut}, 32'h000f);
    waitPulse();
    apb(php_pkg::CTRL_ADDR, 1'b1, 32'h00e0);
    clearOptionFitted <= 1'b1;
    resetKey <= 1'b1;
    @(posedge clk);
    resetKey <= 1'b0;
    repeat (3) @(posedge clk);
    checkVal({28'h0, intEnable, auxA, auxB, req}, 32'h6);
    checkVal({16'h0, dataOut}, 32'h0);
    waitPulse();
    endTest("reset");
    test_done();
  end
endmodule
